// ### design/shcm_mailbox.v
// Host command mailbox: parameter, command and response registers
`default_nettype none
`include "shcm_defs.vh"

module shcm_mailbox #(
   parameter [7:0] NOP_CODE = `SHCM_NOP_CODE_DFLT,
   parameter [7:0] RESET_CODE = `SHCM_RESET_CODE_DFLT
) (
   input wire REF_CLK,
   input wire SYS_RST,
   input wire [7:0] REG_ADDR,
   input wire REG_WR,
   input wire REG_RD,
   input wire [7:0] REG_WDATA,
   output reg [7:0] REG_RDATA,
   output reg SEQ_CMD_VALID,
   output reg [7:0] SEQ_CMD,
   output reg [7:0] SEQ_PARAM,
   input wire SEQ_CMD_DONE,
   input wire SEQ_OVF_VALID,
   input wire [2:0] SEQ_OVF_SRC,
   input wire SEQ_SLEEP,
   output reg STANDBY,
   output reg RESP_ERROR
);

   ////////////////////////////////////////////////////////////////////////////////
   // Register state

   reg [7:0] param_reg;
   reg [7:0] param_next;
   reg [7:0] cmd_reg;
   reg [7:0] cmd_next;
   reg [7:0] resp_reg;
   reg [7:0] resp_next;
   reg [7:0] rdata_next;
   reg standby_next;
   reg dispatch_next;

   wire wr_param;
   wire wr_cmd;
   wire wr_resp;
   wire err_held;
   wire is_clear_cmd;
   wire accept_cmd;
   wire ovf_hit;
   wire [7:0] ovf_code;
   wire [3:0] cnt_inc;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode

   assign wr_param = REG_WR && (REG_ADDR == `SHCM_ADDR_PARAM);
   assign wr_cmd = REG_WR && (REG_ADDR == `SHCM_ADDR_CMD);
   assign wr_resp = REG_WR && (REG_ADDR == `SHCM_ADDR_RESP);

   assign err_held = resp_reg[`SHCM_RESP_ERR_BIT];
   assign is_clear_cmd = (REG_WDATA == NOP_CODE) || (REG_WDATA == RESET_CODE);
   // Only dispatch is gated; command readback, wake and overflow paths stay open
   assign accept_cmd = wr_cmd && (!err_held || is_clear_cmd);
   assign cnt_inc = resp_reg[`SHCM_CNT_MSB:0] + `SHCM_CNT_ONE;

   ////////////////////////////////////////////////////////////////////////////////
   // Overflow source to error code

   shcm_error_map u_error_map (
      .ovf_valid(SEQ_OVF_VALID),
      .ovf_src(SEQ_OVF_SRC),
      .hit(ovf_hit),
      .code(ovf_code)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Mailbox registers

   always @* begin
      param_next = param_reg;
      cmd_next = cmd_reg;
      if (wr_param) begin
         param_next = REG_WDATA;
      end
      if (wr_cmd) begin
         // Readback shows the last write even when it was refused
         cmd_next = REG_WDATA;
      end
   end

   always @* begin
      dispatch_next = accept_cmd;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Response register

   // Priority: overflow, then error clear, then completion, then host write.
   // An overflow in the clearing cycle wins so no error is lost.
   always @* begin
      resp_next = resp_reg;
      if (ovf_hit) begin
         resp_next = ovf_code;
      end else if (accept_cmd && is_clear_cmd && err_held) begin
         resp_next = `SHCM_RESP_RST;
      end else if (SEQ_CMD_DONE && !err_held) begin
         // Counter frozen while an error is held, so the code survives
         resp_next = {`SHCM_CNT_UPPER_ZERO, cnt_inc};
      end else if (wr_resp && !err_held) begin
         // Host may preload the counter only, so it can never fake or wipe an error
         resp_next = {`SHCM_CNT_UPPER_ZERO, REG_WDATA[`SHCM_CNT_MSB:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Standby

   // Wake beats a same-cycle sleep request so the command is not stranded
   always @* begin
      standby_next = STANDBY;
      if (wr_cmd) begin
         standby_next = 1'b0;
      end else if (SEQ_SLEEP) begin
         standby_next = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read path

   always @* begin
      rdata_next = REG_RDATA;
      if (REG_RD) begin
         case (REG_ADDR)
            `SHCM_ADDR_PARAM: rdata_next = param_reg;
            `SHCM_ADDR_CMD: rdata_next = cmd_reg;
            `SHCM_ADDR_RESP: rdata_next = resp_reg;
            default: rdata_next = `SHCM_RDATA_UNMAPPED;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Flip-flops

   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         param_reg <= `SHCM_PARAM_RST;
         cmd_reg <= `SHCM_CMD_RST;
         resp_reg <= `SHCM_RESP_RST;
         REG_RDATA <= `SHCM_RDATA_UNMAPPED;
         SEQ_CMD_VALID <= 1'b0;
         SEQ_CMD <= `SHCM_CMD_RST;
         SEQ_PARAM <= `SHCM_PARAM_RST;
         STANDBY <= 1'b1;
         RESP_ERROR <= 1'b0;
      end else begin
         param_reg <= param_next;
         cmd_reg <= cmd_next;
         resp_reg <= resp_next;
         REG_RDATA <= rdata_next;
         SEQ_CMD_VALID <= dispatch_next;
         if (dispatch_next) begin
            SEQ_CMD <= REG_WDATA;
            // Parameter written in the same cycle as the command is included
            SEQ_PARAM <= param_next;
         end
         STANDBY <= standby_next;
         RESP_ERROR <= resp_next[`SHCM_RESP_ERR_BIT];
      end
   end

endmodule

`default_nettype wire

// ### design/shcm_defs.vh
// Constants for the sensor host command mailbox
`ifndef SHCM_DEFS_VH
`define SHCM_DEFS_VH

// Register offsets
`define SHCM_ADDR_PARAM 8'h17
`define SHCM_ADDR_CMD 8'h18
`define SHCM_ADDR_RESP 8'h20

// Reset values
`define SHCM_PARAM_RST 8'h00
`define SHCM_CMD_RST 8'h00
`define SHCM_RESP_RST 8'h00
`define SHCM_RDATA_UNMAPPED 8'h00

// Response register layout
`define SHCM_RESP_ERR_BIT 7
`define SHCM_CNT_MSB 3
`define SHCM_CNT_ONE 4'h1
`define SHCM_CNT_UPPER_ZERO 4'h0

// Default command opcodes (opcodes are parameters of the top)
`define SHCM_NOP_CODE_DFLT 8'h00
`define SHCM_RESET_CODE_DFLT 8'h01

// Overflow source channel numbers
`define SHCM_SRC_PROX1 3'h0
`define SHCM_SRC_PROX2 3'h1
`define SHCM_SRC_PROX3 3'h2
`define SHCM_SRC_VIS 3'h3
`define SHCM_SRC_IR 3'h4
`define SHCM_SRC_AUX 3'h5

// Error codes, all but SHCM_ERR_NONE with the top bit set
`define SHCM_ERR_PROX1 8'h88
`define SHCM_ERR_PROX2 8'h89
`define SHCM_ERR_PROX3 8'h8A
`define SHCM_ERR_VIS 8'h8C
`define SHCM_ERR_IR 8'h8D
`define SHCM_ERR_AUX 8'h8E
`define SHCM_ERR_NONE 8'h00

`endif

// ### design/shcm_error_map.v
// Maps an ADC overflow source channel to its response error code
`default_nettype none
`include "shcm_defs.vh"

module shcm_error_map (
   input wire ovf_valid,
   input wire [2:0] ovf_src,
   output reg hit,
   output reg [7:0] code
);

   always @* begin
      hit = ovf_valid;
      code = `SHCM_ERR_NONE;
      case (ovf_src)
         `SHCM_SRC_PROX1: code = `SHCM_ERR_PROX1;
         `SHCM_SRC_PROX2: code = `SHCM_ERR_PROX2;
         `SHCM_SRC_PROX3: code = `SHCM_ERR_PROX3;
         `SHCM_SRC_VIS: code = `SHCM_ERR_VIS;
         `SHCM_SRC_IR: code = `SHCM_ERR_IR;
         `SHCM_SRC_AUX: code = `SHCM_ERR_AUX;
         default: begin
            // Unknown source numbers cannot be reported, so drop them
            hit = 1'b0;
            code = `SHCM_ERR_NONE;
         end
      endcase
   end

endmodule

`default_nettype wire

// ### bench/shcm_seq_model.sv
// Sequencer stand-in that finishes each dispatched command late or soon
`default_nettype none
module shcm_seq_model (
   input wire logic clk,
   input wire logic start,
   input wire logic slow,
   output var logic done = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   // Slow mode mimics a measurement already running when the command lands
   always @(posedge clk) begin
      done <= cnt == 1;
      cnt <= start ? (slow ? 6 : 1) : (cnt > 0 ? cnt - 1 : 0);
   end
endmodule
`default_nettype wire

// ### bench/shcm_mailbox_checker.sv
// Port assertions for the command mailbox
`default_nettype none
module shcm_mailbox_checker (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic SEQ_CMD_VALID,
   input wire logic [7:0] SEQ_CMD,
   input wire logic [7:0] SEQ_PARAM,
   input wire logic SEQ_OVF_VALID,
   input wire logic [2:0] SEQ_OVF_SRC,
   input wire logic STANDBY,
   input wire logic RESP_ERROR
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   wire cw = REG_WR && REG_ADDR == 8'h18;
   // Opcodes 0x00 and 0x01 are the default clear commands
   wire ok = cw && REG_WDATA < 8'h02;
   disp_cmd_a: assert property (cw && !RESP_ERROR |=>
      SEQ_CMD_VALID && SEQ_CMD == $past(REG_WDATA)) else $error("no dispatch");
   param_pass_a: assert property (REG_WR && REG_ADDR == 8'h17 ##1 cw && !RESP_ERROR |=>
      SEQ_PARAM == $past(REG_WDATA, 2)) else $error("param lost");
   stay_asleep_a: assert property (STANDBY && !cw |=> STANDBY)
      else $error("woke");
   cmd_wake_a: assert property (cw |=> !STANDBY)
      else $error("no wake");
   err_set_a: assert property (SEQ_OVF_VALID && SEQ_OVF_SRC < 3'h6 |=> RESP_ERROR)
      else $error("no error");
   err_keep_a: assert property (RESP_ERROR && !ok |=> RESP_ERROR)
      else $error("error lost");
   err_block_a: assert property (RESP_ERROR && cw && !ok |=> !SEQ_CMD_VALID)
      else $error("not refused");
   err_clear_a: assert property (RESP_ERROR && ok && !SEQ_OVF_VALID |=>
      !RESP_ERROR && SEQ_CMD_VALID) else $error("no clear");
   cover property (SEQ_CMD_VALID);
   cover property (RESP_ERROR ##1 !RESP_ERROR);
   cover property (STANDBY ##1 !STANDBY);
endmodule
bind shcm_mailbox shcm_mailbox_checker shcm_mailbox_checker_i (.*);
`default_nettype wire

// ### bench/test_sensor_host_command_mailbox.sv
// Bench for the command mailbox
`default_nettype none
module test_sensor_host_command_mailbox;
   timeunit 1ns;
   timeprecision 1ns;
   logic REF_CLK = 0, SYS_RST = 1, REG_WR = 0, REG_RD = 0, SEQ_OVF_VALID = 0, SEQ_SLEEP = 0;
   logic SEQ_CMD_VALID, SEQ_CMD_DONE, STANDBY, RESP_ERROR, slow = 0;
   logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, SEQ_CMD, SEQ_PARAM;
   logic [2:0] SEQ_OVF_SRC = 3'h0;
   logic [7:0] codes [6] = '{8'h88, 8'h89, 8'h8A, 8'h8C, 8'h8D, 8'h8E};
   int num_errors = 0, n_compared = 0;
   shcm_mailbox shcm_mailbox_i (.*);
   shcm_seq_model shcm_seq_model_i (
      .clk(REF_CLK),
      .start(SEQ_CMD_VALID),
      .slow(slow),
      .done(SEQ_CMD_DONE)
   );
   initial forever #20 REF_CLK = ~REF_CLK;
   task automatic bus(logic w, logic r, logic [7:0] a, logic [7:0] d);
      @(negedge REF_CLK);
      REG_WR = w;
      REG_RD = r;
      REG_ADDR = a;
      REG_WDATA = d;
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      bus(1'b1, 1'b0, a, d);
      bus(1'b0, 1'b0, a, d);
   endtask
   // Completion time is not fixed, so the host polls
   task automatic rd(logic [7:0] a, logic [7:0] exp);
      repeat (12) begin
         bus(1'b0, 1'b1, a, 8'h00);
         bus(1'b0, 1'b0, a, 8'h00);
         if (REG_RDATA === exp) break;
      end
      n_compared++;
      if (REG_RDATA !== exp) begin
         $display("CHECK FAILED read %h exp %h got %h", a, exp, REG_RDATA);
         num_errors++;
      end
   endtask
   task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("CHECK FAILED %s exp %h got %h", name, exp, got);
         num_errors++;
      end
   endtask
   task automatic ovf(logic [2:0] s);
      @(negedge REF_CLK);
      SEQ_OVF_SRC = s;
      SEQ_OVF_VALID = 1;
      @(negedge REF_CLK);
      SEQ_OVF_VALID = 0;
   endtask
   task automatic complete_run;
      if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      complete_run;
   end
   initial begin
      repeat (20) @(negedge REF_CLK);
      SYS_RST = 0;
      rd(8'h17, 8'h00);
      rd(8'h30, 8'h00);
      chk("standby", 8'h01, {7'h00, STANDBY});
      for (int i = 1; i < 18; i++) begin
         slow = i[0];
         // Back to sleep first, so the parameter write is made in standby
         @(negedge REF_CLK);
         SEQ_SLEEP = 1;
         bus(1'b1, 1'b0, 8'h17, 8'(i));
         SEQ_SLEEP = 0;
         bus(1'b1, 1'b0, 8'h18, 8'h05);
         chk("standby", 8'h01, {7'h00, STANDBY});
         bus(1'b0, 1'b0, 8'h18, 8'h05);
         chk("standby", 8'h00, {7'h00, STANDBY});
         chk("dispatch", 8'h01, {7'h00, SEQ_CMD_VALID});
         chk("command", 8'h05, SEQ_CMD);
         chk("parameter", 8'(i), SEQ_PARAM);
         rd(8'h20, 8'(i % 16));
      end
      for (int i = 0; i < 6; i++) begin
         ovf(3'(i));
         rd(8'h20, codes[i]);
         chk("error flag", 8'h01, {7'h00, RESP_ERROR});
         wr(8'h18, 8'h07);
         chk("dispatch", 8'h00, {7'h00, SEQ_CMD_VALID});
         chk("command", (i == 0) ? 8'h05 : 8'((i - 1) % 2), SEQ_CMD);
         rd(8'h20, codes[i]);
         rd(8'h18, 8'h07);
         wr(8'h20, 8'h55);
         rd(8'h20, codes[i]);
         ovf(3'(5 - i));
         rd(8'h20, codes[5 - i]);
         wr(8'h18, 8'(i % 2));
         chk("dispatch", 8'h01, {7'h00, SEQ_CMD_VALID});
         chk("error flag", 8'h00, {7'h00, RESP_ERROR});
         rd(8'h20, 8'h01);
      end
      // Source numbers past the last channel must not disturb the counter
      ovf(3'h6);
      rd(8'h20, 8'h01);
      wr(8'h20, 8'hA6);
      rd(8'h20, 8'h06);
      complete_run;
   end
endmodule
`default_nettype wire
